/* hw/window_watchdog_supervisor.sv */
// window watchdog supervisor: config registers, timer, reset pulse on the inhibit output
`timescale 1ns/1ns
// Function
// - mode field 7:5: 001 off, 010 timeout, 100 window
// - microcontroller reset by dropping the inhibit output
// - config writes accepted in Standby only
// - activation uses latest written configuration
// - accepted config write restarts timer immediately
// - window behaviour only in Normal mode
// - write outside Standby: reset plus illegal flag
// - window trigger restarts only inside window
// - prescale 4:3 gives 1, 1.5, 2.5, 3.5
// - sleep-run set: sleep entry restarts counting
// - sleep-run clear: hold until inhibit rises
// - long-window bit: inhibit rise opens long window
// - discharger active during watchdog reset when enabled
// - period field 7:4 decodes to milliseconds
// - one period serves window and timeout
// - trigger register pattern 01010101 restarts timer
// - low nibble selects reset pulse length
// - overflow or early trigger resets; late restarts
// - invalid code write discarded, corrupted flag set
// - status flags 6:5 and 3:1 cleared by writing one
module window_watchdog_supervisor
  import supervisor_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)(
  input  wire logic       clock_i,                   // 50 MHz system clock
  input  wire logic       rst_b_i,                   // synchronous reset, active low
  input  wire dev_mode_t  dev_mode_i,                // device operating mode
  input  wire logic       inh_request_i,             // mode control wants inhibit on
  input  wire reg_req_t   reg_req_i,                 // register write request
  output logic [7:0]      reg_rdata_o,               // register read data, one cycle late
  output logic            inhibit_supply_output_o,   // inhibit supply switch
  output logic            supply_discharger_enable_o,// io_supply_pin discharge on
  output logic            reset_mode_o               // watchdog reset pulse running
);

  if (TICK_CYCLES_P < 2 || TICK_CYCLES_P > 65536) begin : g_tick_chk
    $error("window_watchdog_supervisor: TICK_CYCLES_P must lie in 2..65536");
  end

  wd_regs_t s_r;
  wd_regs_t s_nxt;

  logic             tick;
  logic             cfg_wr;
  logic             standby;
  logic             code_valid;
  logic             trig_wr;
  logic             status_wr;
  logic             window_eff;
  logic             first_half;
  logic             sleep_entry;
  logic             inh_rise;
  logic             active;
  logic [2:0]       new_mode;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] pulse_len;

  // private timebase so a stuck system clock divider cannot silence the timer
  supervisor_timebase #(
    .DIV (TICK_CYCLES_P)
  ) u_timebase (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .tick_o  (tick)
  );

  assign cfg_wr    = reg_req_i.wr &&
                     (reg_req_i.addr == CFG_ONE_ADDR || reg_req_i.addr == CFG_TWO_ADDR);
  assign status_wr = reg_req_i.wr && (reg_req_i.addr == STATUS_ADDR);
  assign trig_wr   = reg_req_i.wr && (reg_req_i.addr == TRIG_ADDR) &&
                     (reg_req_i.wdata == TRIG_PATTERN);
  assign standby   = (dev_mode_i == DM_STANDBY);
  assign new_mode  = reg_req_i.wdata[MODE_LSB +: 3];

  // prescale bits take any value; the redundant fields must all be valid
  assign code_valid = (reg_req_i.addr == CFG_ONE_ADDR) ? mode_ok(new_mode) :
                      (code_ok(reg_req_i.wdata[PERIOD_LSB +: 4]) &&
                       code_ok(reg_req_i.wdata[PULSE_LSB +: 4]));

  assign limit     = period_ticks(s_r.cfg2[PERIOD_LSB +: 4], s_r.cfg1[PRE_LSB +: 2]);
  assign pulse_len = pulse_ticks(s_r.cfg2[PULSE_LSB +: 4]);

  assign window_eff  = (s_r.cfg1[MODE_LSB +: 3] == MODE_WINDOW) && (dev_mode_i == DM_NORMAL);
  assign first_half  = window_eff && (s_r.st == ST_RUN) && (s_r.cnt < (limit >> 1));
  assign sleep_entry = (dev_mode_i == DM_SLEEP) && !s_r.in_sleep;
  assign inh_rise    = s_r.inhibit_supply_output && !s_r.inh_d;
  assign active      = (s_r.st == ST_LONG) || (s_r.st == ST_RUN);

  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.in_sleep = (dev_mode_i == DM_SLEEP);
    s_nxt.inh_d    = s_r.inhibit_supply_output;

    // clear first so that a same-cycle hardware set below still wins
    if (status_wr)
      s_nxt.flags = s_r.flags & ~(reg_req_i.wdata & STATUS_W1C_MASK);

    case (s_r.st)
      ST_OFF:
      begin
        s_nxt.cnt = '0;
      end
      ST_LONG:
      begin
        if (trig_wr)
        begin
          s_nxt.st  = ST_RUN;
          s_nxt.cnt = '0;
        end
        else if (tick && s_r.cnt == LONG_WINDOW_TICKS - CNT_W'(1))
        begin
          s_nxt.flags[OVF_BIT] = 1'b1;
          s_nxt.st             = ST_PULSE;
          s_nxt.cnt            = '0;
        end
        else if (tick)
          s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
      ST_RUN:
      begin
        if (trig_wr && first_half)
        begin
          s_nxt.flags[EARLY_BIT] = 1'b1;
          s_nxt.st               = ST_PULSE;
          s_nxt.cnt              = '0;
        end
        else if (trig_wr)
          s_nxt.cnt = '0;
        else if (tick && s_r.cnt >= limit - CNT_W'(1))
        begin
          // in sleep this doubles as the cyclic wake-up
          if (dev_mode_i == DM_SLEEP)
            s_nxt.flags[OVF_SLEEP_BIT] = 1'b1;
          else
            s_nxt.flags[OVF_BIT] = 1'b1;
          s_nxt.st  = ST_PULSE;
          s_nxt.cnt = '0;
        end
        else if (tick)
          s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
      ST_HOLD:
      begin
        s_nxt.cnt = '0;
        if (inh_rise)
          s_nxt.st = s_r.cfg1[LONG_WIN_BIT] ? ST_LONG : ST_RUN;
      end
      ST_PULSE:
      begin
        if (tick && s_r.cnt >= pulse_len - CNT_W'(1))
        begin
          s_nxt.cnt = '0;
          s_nxt.st  = (s_r.cfg1[MODE_LSB +: 3] == MODE_OFF) ? ST_OFF : ST_RUN;
        end
        else if (tick)
          s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
      default:
      begin
        s_nxt.st  = ST_OFF;
        s_nxt.cnt = '0;
      end
    endcase

    // sleep entry and inhibit rise only reshape an active timer
    if (active && sleep_entry)
    begin
      s_nxt.cnt = '0;
      if (s_r.cfg1[SLEEP_RUN_BIT])
        s_nxt.st = ST_RUN;
      else
        s_nxt.st = ST_HOLD;
    end
    else if (active && dev_mode_i == DM_OVERTEMP)
    begin
      s_nxt.cnt = '0;
      s_nxt.st  = ST_HOLD;
    end
    else if (active && inh_rise && s_r.cfg1[LONG_WIN_BIT])
    begin
      s_nxt.cnt = '0;
      s_nxt.st  = ST_LONG;
    end

    // configuration writes take priority over the timer
    if (cfg_wr)
    begin
      if (!standby)
      begin
        s_nxt.flags[ILL_BIT] = 1'b1;
        s_nxt.st             = ST_PULSE;
        s_nxt.cnt            = '0;
      end
      else if (!code_valid)
        s_nxt.flags[CORRUPTED_ACCESS_FLAG_BIT] = 1'b1;
      else
      begin
        if (reg_req_i.addr == CFG_ONE_ADDR)
          s_nxt.cfg1 = reg_req_i.wdata;
        else
          s_nxt.cfg2 = reg_req_i.wdata;
        s_nxt.cnt = '0;
        if (reg_req_i.addr == CFG_ONE_ADDR && new_mode == MODE_OFF)
          s_nxt.st = ST_OFF;
        else if (s_r.st == ST_OFF && reg_req_i.addr == CFG_ONE_ADDR)
        begin
          // leftover error flags at enable give an immediate reset
          if (s_nxt.flags[CORRUPTED_ACCESS_FLAG_BIT] || s_nxt.flags[ILL_BIT])
            s_nxt.st = ST_PULSE;
          else
            s_nxt.st = ST_LONG;
        end
      end
    end

    s_nxt.flags[OFF_BIT]        = (s_nxt.st == ST_OFF);
    s_nxt.flags[FIRST_HALF_BIT] = first_half;
    s_nxt.flags[0]              = 1'b0;

    s_nxt.inhibit_supply_output      = inh_request_i && (s_nxt.st != ST_PULSE);
    s_nxt.disch    = (s_nxt.st == ST_PULSE) && s_nxt.cfg1[DISCH_BIT];
    s_nxt.rst_mode = (s_nxt.st == ST_PULSE);

    case (reg_req_i.addr)
      CFG_ONE_ADDR: s_nxt.rdata = s_r.cfg1;
      CFG_TWO_ADDR: s_nxt.rdata = s_r.cfg2;
      STATUS_ADDR:  s_nxt.rdata = s_r.flags;
      default:      s_nxt.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      s_r          <= '0;
      s_r.st       <= ST_OFF;
      s_r.cfg1     <= CFG_ONE_RST;
      s_r.cfg2     <= CFG_TWO_RST;
      s_r.flags    <= STATUS_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign reg_rdata_o                = s_r.rdata;
  assign inhibit_supply_output_o    = s_r.inhibit_supply_output;
  assign supply_discharger_enable_o = s_r.disch;
  assign reset_mode_o               = s_r.rst_mode;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_INH_OFF_IN_PULSE: assert property (
    reset_mode_o |-> !inhibit_supply_output_o)
    else $error("inhibit high during watchdog reset pulse");

  AST_ILLEGAL_WRITE: assert property (
    (cfg_wr && !standby) |=> (s_r.flags[ILL_BIT] && s_r.st == ST_PULSE && reset_mode_o))
    else $error("config write outside standby did not reset");

  AST_NO_CFG_OUTSIDE_STANDBY: assert property (
    (cfg_wr && !standby) |=> ($stable(s_r.cfg1) && $stable(s_r.cfg2)))
    else $error("config changed outside standby");

  AST_CORRUPT_DISCARD: assert property (
    (cfg_wr && standby && !code_valid)
      |=> (s_r.flags[CORRUPTED_ACCESS_FLAG_BIT] && $stable(s_r.cfg1) && $stable(s_r.cfg2)))
    else $error("invalid code not discarded");

  AST_WRITE_RESTART: assert property (
    (cfg_wr && standby && code_valid && active) |=> (s_r.cnt == '0))
    else $error("accepted config write did not restart timer");

  AST_EARLY_TRIGGER: assert property (
    (trig_wr && first_half && !cfg_wr) |=> (s_r.flags[EARLY_BIT] && s_r.st == ST_PULSE))
    else $error("early trigger did not reset");

  AST_LATE_TRIGGER: assert property (
    (trig_wr && s_r.st == ST_RUN && !first_half && !cfg_wr && !sleep_entry
     && dev_mode_i != DM_OVERTEMP && !inh_rise) |=> (s_r.cnt == '0 && s_r.st == ST_RUN))
    else $error("valid trigger did not restart timer");

  AST_DISCHARGE: assert property (
    supply_discharger_enable_o |-> (reset_mode_o && s_r.cfg1[DISCH_BIT]))
    else $error("discharger on outside enabled reset pulse");

  AST_SLEEP_HOLD: assert property (
    (s_r.st == ST_HOLD) |-> (s_r.cnt == '0))
    else $error("held timer is counting");

  AST_LONG_WINDOW: assert property (
    (active && inh_rise && s_r.cfg1[LONG_WIN_BIT] && !sleep_entry && !cfg_wr
     && dev_mode_i != DM_OVERTEMP) |=> (s_r.st == ST_LONG && s_r.cnt == '0))
    else $error("inhibit rise did not open long window");

endmodule

/* hw/supervisor_pkg.sv */
// package: constants, field layout and types of the window watchdog supervisor
package supervisor_pkg;

  localparam int CNT_W = 19;

  localparam logic [6:0] CFG_ONE_ADDR = 7'h36;
  localparam logic [6:0] CFG_TWO_ADDR = 7'h37;
  localparam logic [6:0] STATUS_ADDR  = 7'h38;
  localparam logic [6:0] TRIG_ADDR    = 7'h39;

  localparam logic [7:0] CFG_ONE_RST     = 8'h22;
  localparam logic [7:0] CFG_TWO_RST     = 8'h47;
  localparam logic [7:0] STATUS_RST      = 8'h80;
  localparam logic [7:0] TRIG_PATTERN    = 8'h55;
  localparam logic [7:0] STATUS_W1C_MASK = 8'h6E;

  localparam int MODE_LSB      = 5;
  localparam int PRE_LSB       = 3;
  localparam int SLEEP_RUN_BIT = 2;
  localparam int LONG_WIN_BIT  = 1;
  localparam int DISCH_BIT     = 0;
  localparam int PERIOD_LSB    = 4;
  localparam int PULSE_LSB     = 0;

  localparam int OFF_BIT        = 7;
  localparam int CORRUPTED_ACCESS_FLAG_BIT       = 6;
  localparam int ILL_BIT        = 5;
  localparam int FIRST_HALF_BIT = 4;
  localparam int OVF_BIT        = 3;
  localparam int OVF_SLEEP_BIT  = 2;
  localparam int EARLY_BIT      = 1;

  localparam logic [2:0] MODE_OFF     = 3'h1;
  localparam logic [2:0] MODE_TIMEOUT = 3'h2;
  localparam logic [2:0] MODE_WINDOW  = 3'h4;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_NS        = 100_000;
  localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
  localparam int LONG_WINDOW_MS = 600;
  localparam logic [CNT_W-1:0] TICKS_PER_MS      = CNT_W'(1_000_000 / TICK_NS);
  localparam logic [CNT_W-1:0] LONG_WINDOW_TICKS = CNT_W'(LONG_WINDOW_MS * 1_000_000 / TICK_NS);

  typedef enum logic [2:0] {
    DM_STANDBY  = 3'b000,
    DM_NORMAL   = 3'b001,
    DM_SLEEP    = 3'b010,
    DM_RESET    = 3'b011,
    DM_OVERTEMP = 3'b100
  } dev_mode_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_LONG  = 3'b001,
    ST_RUN   = 3'b010,
    ST_HOLD  = 3'b011,
    ST_PULSE = 3'b100
  } wd_state_t;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    wd_state_t        st;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       cfg1;
    logic [7:0]       cfg2;
    logic [7:0]       flags;
    logic [7:0]       rdata;
    logic             inhibit_supply_output;
    logic             inh_d;
    logic             disch;
    logic             rst_mode;
    logic             in_sleep;
  } wd_regs_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_regs_t;

  // redundant codes: a single flipped bit never lands on another valid code
  function automatic logic code_ok(input logic [3:0] c);
    case (c)
      4'h8, 4'h1, 4'h2, 4'hB, 4'h4, 4'hD, 4'hE, 4'h7: code_ok = 1'b1;
      default: code_ok = 1'b0;
    endcase
  endfunction

  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m == MODE_OFF) || (m == MODE_TIMEOUT) || (m == MODE_WINDOW);
  endfunction

  function automatic logic [CNT_W-1:0] period_ticks(input logic [3:0] c, input logic [1:0] pre);
    logic [CNT_W-1:0] ms;
    logic [CNT_W-1:0] half_factor;
    case (c)
      4'h8:    ms = CNT_W'(8);
      4'h1:    ms = CNT_W'(16);
      4'h2:    ms = CNT_W'(32);
      4'hB:    ms = CNT_W'(64);
      4'hD:    ms = CNT_W'(256);
      4'hE:    ms = CNT_W'(1024);
      4'h7:    ms = CNT_W'(4096);
      default: ms = CNT_W'(128);
    endcase
    case (pre)
      2'h1:    half_factor = CNT_W'(3);
      2'h2:    half_factor = CNT_W'(5);
      2'h3:    half_factor = CNT_W'(7);
      default: half_factor = CNT_W'(2);
    endcase
    period_ticks = CNT_W'((ms * TICKS_PER_MS * half_factor) >> 1);
  endfunction

  // shortest pulse of each band, in tenths of a millisecond
  function automatic logic [CNT_W-1:0] pulse_ticks(input logic [3:0] c);
    logic [CNT_W-1:0] tenths;
    case (c)
      4'h8:    tenths = CNT_W'(10);
      4'h1:    tenths = CNT_W'(36);
      4'h2:    tenths = CNT_W'(100);
      4'hB:    tenths = CNT_W'(200);
      4'h4:    tenths = CNT_W'(400);
      4'hD:    tenths = CNT_W'(600);
      4'hE:    tenths = CNT_W'(1000);
      default: tenths = CNT_W'(1500);
    endcase
    pulse_ticks = CNT_W'((tenths * TICKS_PER_MS) / CNT_W'(10));
  endfunction

endpackage

/* hw/supervisor_timebase.sv */
// timebase: one-cycle tick every DIV clocks, standing in for the private oscillator
`timescale 1ns/1ns
module supervisor_timebase
  import supervisor_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
)(
  input  wire logic clock_i,  // system clock
  input  wire logic rst_b_i,  // synchronous reset, active low
  output logic      tick_o    // one-cycle tick
);

  if (DIV < 2 || DIV > 65536) begin : g_div_chk
    $error("supervisor_timebase: DIV must lie in 2..65536");
  end

  tick_regs_t s_r;
  tick_regs_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (s_r.cnt == 16'(DIV - 1))
    begin
      s_nxt.cnt  = 16'h0000;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt  = s_r.cnt + 16'h0001;
      s_nxt.tick = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick_o = s_r.tick;

endmodule

/* test/host_mcu_model.sv */
// host model: microcontroller side of the register port
`timescale 1ns/1ns
module host_mcu_model
  import supervisor_pkg::*;
(
  input  wire logic       clock_i,  // system clock
  output reg_req_t        req_o,    // register request
  input  wire logic [7:0] rdata_i   // registered read data
);
  initial req_o = '0;

  // one-cycle write strobe, then data inverted so stale bytes never repeat the written byte
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req_o <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clock_i);
    req_o.wr    <= 1'b0;
    req_o.wdata <= ~d;
  endtask

  // read data follows the address one cycle later; taken mid-cycle, clear of the edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clock_i);
    req_o.addr <= a;
    @(posedge clock_i);
    @(negedge clock_i);
    d = rdata_i;
  endtask

  task automatic trig();
    wr(TRIG_ADDR, TRIG_PATTERN);
  endtask
endmodule

/* test/test_window_watchdog_supervisor.sv */
// bench: register defaults, refusals, timeout, window and illegal-write checks
`timescale 1ns/1ns
module test_window_watchdog_supervisor
  import supervisor_pkg::*;
();
  localparam int TCK = 4;
  logic       clock_i = 1'b0;
  logic       rst_b_i = 1'b0;
  dev_mode_t  dev_mode = DM_STANDBY;
  logic       inh_req = 1'b1;
  reg_req_t   req;
  logic [7:0] rdata;
  logic       inhibit_supply_output;
  logic       disch;
  logic       rmode;
  logic       rmode_q = 1'b0;
  logic [7:0] v;
  int         n_errors = 0;
  int         samples_checked = 0;
  int         n_pulse = 0;
  int         cyc = 0;
  int         n;
  int         k;

  always #10 clock_i = ~clock_i;

  window_watchdog_supervisor #(.TICK_CYCLES_P(TCK)) dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .dev_mode_i(dev_mode),
    .inh_request_i(inh_req), .reg_req_i(req), .reg_rdata_o(rdata),
    .inhibit_supply_output_o(inhibit_supply_output), .supply_discharger_enable_o(disch),
    .reset_mode_o(rmode));

  host_mcu_model host (.clock_i(clock_i), .req_o(req), .rdata_i(rdata));

  // pulse counter and hang guard; a run should need well under 10k cycles
  always @(posedge clock_i)
  begin
    rmode_q <= rmode;
    if (rmode === 1'b1 && rmode_q === 1'b0)
      n_pulse++;
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_n(input int g, input int lo, input int hi);
    samples_checked++;
    if (g < lo || g > hi)
    begin
      n_errors++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk(v, e);
  endtask

  task automatic wait_lvl(input logic lvl, input int lim);
    n = 0;
    while (rmode !== lvl && n < lim)
    begin
      @(negedge clock_i);
      n++;
    end
  endtask

  task automatic setm(input dev_mode_t m);
    @(posedge clock_i);
    dev_mode <= m;
  endtask

  task automatic t_reset();
    rdc(CFG_ONE_ADDR, 8'h22);
    rdc(CFG_TWO_ADDR, 8'h47);
    rdc(STATUS_ADDR, 8'h80);
    rdc(TRIG_ADDR, 8'h00);
    chk({7'h0, rmode}, 8'h00);
  endtask

  task automatic t_corrupt();
    host.wr(CFG_ONE_ADDR, 8'h62);
    rdc(CFG_ONE_ADDR, 8'h22);
    host.wr(CFG_TWO_ADDR, 8'h83);
    rdc(CFG_TWO_ADDR, 8'h47);
    rdc(STATUS_ADDR, 8'hC0);
    host.wr(STATUS_ADDR, 8'h00);
    rdc(STATUS_ADDR, 8'hC0);
    host.wr(STATUS_ADDR, 8'h40);
    rdc(STATUS_ADDR, 8'h80);
  endtask

  // 8 ms period, prescale 1.5, 1 ms pulse, discharger on
  task automatic t_timeout();
    host.wr(CFG_TWO_ADDR, 8'h88);
    host.wr(CFG_ONE_ADDR, 8'h49);
    rdc(STATUS_ADDR, 8'h00);
    k = n_pulse;
    for (int i = 0; i < 3; i++)
    begin
      repeat (300) @(posedge clock_i);
      if (i == 0)
        host.wr(CFG_TWO_ADDR, 8'h88);
      else
        host.trig();
    end
    chk_n(n_pulse - k, 0, 0);
    wait_lvl(1'b1, 600);
    chk_n(n, 480 - TCK - 4, 480 + TCK + 4);
    chk({7'h0, inhibit_supply_output}, 8'h00);
    chk({7'h0, disch}, 8'h01);
    wait_lvl(1'b0, 200);
    chk_n(n, 40 - TCK - 3, 40 + TCK + 3);
    @(negedge clock_i);
    chk({7'h0, inhibit_supply_output}, 8'h01);
    rdc(STATUS_ADDR, 8'h08);
    host.wr(CFG_ONE_ADDR, 8'h20);
    host.wr(STATUS_ADDR, 8'h08);
    rdc(STATUS_ADDR, 8'h80);
  endtask

  task automatic t_illegal();
    setm(DM_NORMAL);
    host.wr(CFG_TWO_ADDR, 8'h11);
    @(negedge clock_i);
    @(negedge clock_i);
    chk({7'h0, rmode}, 8'h01);
    chk({7'h0, inhibit_supply_output}, 8'h00);
    wait_lvl(1'b0, 200);
    setm(DM_STANDBY);
    rdc(CFG_TWO_ADDR, 8'h88);
    rdc(STATUS_ADDR, 8'hA0);
    host.wr(STATUS_ADDR, 8'h20);
  endtask

  // 320-cycle period: first half ends 160 cycles after a restart
  task automatic t_window();
    host.wr(CFG_ONE_ADDR, 8'h80);
    host.trig();
    k = n_pulse;
    repeat (60) @(posedge clock_i);
    host.trig();
    setm(DM_NORMAL);
    repeat (260) @(posedge clock_i);
    host.trig();
    repeat (60) @(posedge clock_i);
    chk_n(n_pulse - k, 0, 0);
    host.trig();
    wait_lvl(1'b1, 20);
    chk_n(n, 0, 8);
    wait_lvl(1'b0, 200);
    setm(DM_STANDBY);
    host.rd(STATUS_ADDR, v);
    chk(v & 8'hEF, 8'h02);
    host.wr(CFG_ONE_ADDR, 8'h20);
    host.wr(STATUS_ADDR, 8'h02);
  endtask

  // timeout with long window: sleep hold, inhibit rise, then sleep-run restart
  task automatic t_sleep();
    host.wr(CFG_ONE_ADDR, 8'h42);
    host.trig();
    k = n_pulse;
    setm(DM_SLEEP);
    repeat (600) @(posedge clock_i);
    chk_n(n_pulse - k, 0, 0);
    setm(DM_STANDBY);
    @(posedge clock_i);
    inh_req <= 1'b0;
    repeat (2) @(posedge clock_i);
    inh_req <= 1'b1;
    repeat (400) @(posedge clock_i);
    chk_n(n_pulse - k, 0, 0);
    host.trig();
    wait_lvl(1'b1, 400);
    chk_n(n, 320 - TCK - 4, 320 + TCK + 4);
    chk({7'h0, disch}, 8'h00);
    wait_lvl(1'b0, 200);
    host.wr(CFG_ONE_ADDR, 8'h46);
    setm(DM_SLEEP);
    wait_lvl(1'b1, 400);
    chk_n(n, 320 - TCK - 4, 320 + TCK + 4);
    setm(DM_STANDBY);
    wait_lvl(1'b0, 200);
    rdc(STATUS_ADDR, 8'h0C);
    host.wr(CFG_ONE_ADDR, 8'h20);
    host.wr(STATUS_ADDR, 8'h0C);
  endtask

  initial
  begin
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_corrupt();
    t_timeout();
    t_illegal();
    t_window();
    t_sleep();
    final_report();
  end
endmodule
